// ---- design/wii_pkg.sv ----
// Purpose: Shared constants and types for the wake input and interrupt block.
// Assumes: A 25 MHz system clock with a 40 ns period.
// Notes:   Times are held in ns and turned into cycle counts here.
package wii_pkg;

  localparam int unsigned CLK_PERIOD_NS       = 40;
  localparam int unsigned WAKE_FILTER_TIME_NS = 16000;
  localparam int unsigned IRQ_PULSE_TIME_NS   = 100000;
  localparam int unsigned IRQ_MIN_GAP_NS      = 100000;

  // Least times round up to whole cycles.
  localparam int unsigned WAKE_FILTER_CYC =
    (WAKE_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned IRQ_PULSE_CYC =
    (IRQ_PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned IRQ_GAP_CYC =
    (IRQ_MIN_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned STAT_W = 8;
  // Position of the wake pin source flag in the first status register.
  localparam int unsigned PIN_FLAG_BIT = 0;

  typedef enum logic [1:0] {
    WII_NORMAL   = 2'h0,
    WII_STOP     = 2'h1,
    WII_FAILSAFE = 2'h2,
    WII_SLEEP    = 2'h3
  } wii_mode_t;

  typedef enum logic [1:0] {
    WII_BIAS_NONE = 2'h0,
    WII_BIAS_DOWN = 2'h1,
    WII_BIAS_UP   = 2'h2,
    WII_BIAS_AUTO = 2'h3
  } wii_bias_t;

  typedef struct packed {
    logic [STAT_W-1:0] second;
    logic [STAT_W-1:0] first;
  } wii_stat_t;

  typedef struct packed {
    logic pull_up;
    logic pull_down;
  } wii_bias_out_t;

  localparam wii_stat_t     STAT_RESET = '0;
  localparam wii_bias_out_t BIAS_RESET = '0;

endpackage

// ---- design/wii_filter.sv ----
// Purpose: Glitch filter and edge detector for the wake pin.
// Assumes: The pin input is already synchronous to clk_sys.
// Notes:   The first stable level after reset is taken without an edge.
`timescale 1ns/100ps
module wii_filter #(
  parameter int unsigned CYCLES = wii_pkg::WAKE_FILTER_CYC
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rstn,
  // Pin side
  input  wire logic raw,
  // Filtered side
  output logic      level,
  output logic      edge_p
);
  import wii_pkg::*;

  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_q, cnt_d;
  logic          lvl_q, lvl_d;
  logic          primed_q, primed_d;
  logic          edge_q, edge_d;

  always_comb begin
    cnt_d    = cnt_q;
    lvl_d    = lvl_q;
    primed_d = primed_q;
    edge_d   = 1'b0;
    if (primed_q && raw == lvl_q) begin
      cnt_d = '0;
    end else if (cnt_q == LAST) begin
      // The new level held for the whole interval.
      cnt_d    = '0;
      lvl_d    = raw;
      primed_d = 1'b1;
      edge_d   = primed_q;
    end else begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_q    <= '0;
      lvl_q    <= 1'b0;
      primed_q <= 1'b0;
      edge_q   <= 1'b0;
    end else begin
      cnt_q    <= cnt_d;
      lvl_q    <= lvl_d;
      primed_q <= primed_d;
      edge_q   <= edge_d;
    end
  end

  assign level  = lvl_q;
  assign edge_p = edge_q;

endmodule

// ---- design/wii_irq_pulse.sv ----
// Purpose: Shapes the active-low interrupt pulse and the high gap after it.
// Assumes: start is only raised while ready is high.
// Notes:   int_n falls on the edge that takes start.
`timescale 1ns/100ps
module wii_irq_pulse #(
  parameter int unsigned PULSE_CYC = wii_pkg::IRQ_PULSE_CYC,
  parameter int unsigned GAP_CYC   = wii_pkg::IRQ_GAP_CYC
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rstn,
  // Request
  input  wire logic start,
  output logic      ready,
  // Pin
  output logic      int_n
);
  import wii_pkg::*;

  localparam int unsigned MAXC = (PULSE_CYC > GAP_CYC) ? PULSE_CYC : GAP_CYC;
  localparam int unsigned CW   = $clog2(MAXC + 1);
  localparam logic [CW-1:0] P_LAST = CW'(PULSE_CYC - 1);
  localparam logic [CW-1:0] G_LAST = CW'(GAP_CYC - 1);

  typedef enum logic [1:0] {
    WII_P_IDLE = 2'b00,
    WII_P_LOW  = 2'b01,
    WII_P_GAP  = 2'b11
  } wii_pst_t;

  wii_pst_t      st_q, st_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic          int_n_q, int_n_d;

  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q + 1'b1;
    int_n_d = int_n_q;
    unique case (st_q)
      WII_P_IDLE: begin
        cnt_d = '0;
        if (start) begin
          st_d    = WII_P_LOW;
          int_n_d = 1'b0;
        end
      end
      WII_P_LOW: begin
        if (cnt_q == P_LAST) begin
          st_d    = WII_P_GAP;
          cnt_d   = '0;
          int_n_d = 1'b1;
        end
      end
      WII_P_GAP: begin
        if (cnt_q == G_LAST) begin
          st_d  = WII_P_IDLE;
          cnt_d = '0;
        end
      end
      default: begin
        st_d    = WII_P_IDLE;
        cnt_d   = '0;
        int_n_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_q    <= WII_P_IDLE;
      cnt_q   <= '0;
      int_n_q <= 1'b1;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      int_n_q <= int_n_d;
    end
  end

  assign ready = (st_q == WII_P_IDLE);
  assign int_n = int_n_q;

endmodule

// ---- design/wii_wake_irq.sv ----
// Purpose: Wake pin detection, wake status flags and interrupt output.
// Assumes: All inputs are synchronous to clk_sys; mode comes from the
//          mode sequencer outside this block.
// Notes:   In normal and stop, flags are held pending and copied into the visible status at
//          each falling edge of the interrupt pulse.
//
// What this block does
// - Both filtered pin edges are wake events.
// - Interrupt in normal/stop, wake in sleep, restart in fail-safe.
// - In stop, pin low picks PFM, high PWM.
// - Modulation select uses the unfiltered pin level.
// - Static or cyclic sensing, selected by software.
// - Pin edges filtered for 16 us.
// - Wake enable bit gates pin edges.
// - Pin level readable in normal and stop.
// - Fail-safe pin edge requests restart.
// - Pin wake sets the pin source flag.
// - Bias select: none, down, up, automatic.
// - Interrupt pulse low for 100 us.
// - At least 100 us high between pulses.
// - Interrupt pulse never changes power mode.
// - Only enabled sources raise interrupts.
// - Pin level status never interrupts nor latches.
// - Stop entry with flags set interrupts.
// - Automatic PFM to PWM in stop interrupts.
// - Status updated at interrupt falling edge in normal/stop.
// - Flags stay until host clears them.
`timescale 1ns/100ps
module wii_wake_irq #(
  parameter int unsigned FILTER_CYC = wii_pkg::WAKE_FILTER_CYC,
  parameter int unsigned PULSE_CYC  = wii_pkg::IRQ_PULSE_CYC,
  parameter int unsigned GAP_CYC    = wii_pkg::IRQ_GAP_CYC
) (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rstn,
  // Wake pin
  input  wire logic                   wake_pin,
  // Chip state
  input  wire wii_pkg::wii_mode_t     mode,
  // Configuration
  input  wire logic                   wake_enable_bit,
  input  wire logic                   cyclic_sense,
  input  wire logic                   cyclic_window,
  input  wire logic                   pin_selects_modulation,
  input  wire wii_pkg::wii_bias_t     pin_bias_control,
  input  wire wii_pkg::wii_stat_t     src_enable,
  // Events from other wake sources and the buck converter
  input  wire wii_pkg::wii_stat_t     src_event,
  input  wire logic                   buck_pfm_to_pwm,
  // Host clear strobe, one bit per flag
  input  wire wii_pkg::wii_stat_t     stat_clear,
  // Interrupt pin
  output logic                        int_n,
  // Status
  output wii_pkg::wii_stat_t          wake_status,
  output logic                        pin_level_status,
  // Pin bias and buck modulation
  output wii_pkg::wii_bias_out_t      pin_bias,
  output logic                        buck_pin_ctrl,
  output logic                        buck_pwm_sel,
  // Mode requests to the sequencer
  output logic                        wake_req,
  output logic                        restart_req
);
  import wii_pkg::*;

  // Filter outputs.
  logic          filt_level;
  logic          filt_edge;

  // Pulse shaper handshake.
  logic          irq_ready;
  logic          irq_start;

  // Combinational event terms.
  logic          sense_open;
  logic          pin_evt;
  wii_stat_t     evt;
  logic          irq_mode;
  logic          stop_entry;
  logic          buck_evt;
  logic          any_flag;

  // State.
  wii_stat_t     pend_q, pend_d;
  wii_stat_t     stat_q, stat_d;
  logic          irq_req_q, irq_req_d;
  wii_mode_t     mode_prev_q, mode_prev_d;
  logic          level_q, level_d;
  wii_bias_out_t bias_q, bias_d;
  logic          bctl_q, bctl_d;
  logic          bpwm_q, bpwm_d;
  logic          wake_q, wake_d;
  logic          rst_q, rst_d;

  wii_filter #(
    .CYCLES (FILTER_CYC)
  ) u_filter (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .raw     (wake_pin),
    .level   (filt_level),
    .edge_p  (filt_edge)
  );

  wii_irq_pulse #(
    .PULSE_CYC (PULSE_CYC),
    .GAP_CYC   (GAP_CYC)
  ) u_pulse (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .start   (irq_start),
    .ready   (irq_ready),
    .int_n   (int_n)
  );

  // Event qualification.
  always_comb begin
    // In cyclic sensing the pin only counts inside the active window.
    sense_open = !cyclic_sense || cyclic_window;
    pin_evt    = filt_edge && wake_enable_bit && sense_open;
    // Sources that are not enabled never reach the flags.
    evt = wii_stat_t'(src_event & src_enable);
    evt.first[PIN_FLAG_BIT] = pin_evt;
    irq_mode = (mode == WII_NORMAL) || (mode == WII_STOP);
    any_flag = |(stat_q | pend_q);
    stop_entry = (mode == WII_STOP) && (mode_prev_q != WII_STOP)
                 && any_flag;
    buck_evt = (mode == WII_STOP) && buck_pfm_to_pwm;
    // A pulse starts only when the gap after the last one is over.
    irq_start = irq_req_q && irq_ready && irq_mode;
  end

  // Status flags and the queued interrupt request.
  always_comb begin
    pend_d      = pend_q;
    stat_d      = wii_stat_t'(stat_q & ~stat_clear);
    irq_req_d   = irq_req_q;
    mode_prev_d = mode;
    if (irq_mode) begin
      if (irq_start) begin
        // Visible flags change with the falling pulse edge.
        stat_d = wii_stat_t'(stat_d | pend_q);
        pend_d = evt;
      end else begin
        pend_d = wii_stat_t'(pend_q | evt);
      end
      if (irq_start) begin
        irq_req_d = 1'b0;
      end
      // A request arriving now is kept for a later pulse.
      if ((|evt) || stop_entry || buck_evt) begin
        irq_req_d = 1'b1;
      end
    end else begin
      // No pulse in sleep or fail-safe: flags latch at once.
      stat_d    = wii_stat_t'(stat_d | pend_q | evt);
      pend_d    = STAT_RESET;
      irq_req_d = 1'b0;
    end
  end

  // Pin level, bias, modulation select and mode requests.
  always_comb begin
    // Plain level copy with no latching and no interrupt path.
    level_d = irq_mode ? filt_level : level_q;
    unique case (pin_bias_control)
      WII_BIAS_NONE: bias_d = BIAS_RESET;
      WII_BIAS_DOWN: bias_d = '{pull_up: 1'b0, pull_down: 1'b1};
      WII_BIAS_UP:   bias_d = '{pull_up: 1'b1, pull_down: 1'b0};
      WII_BIAS_AUTO: bias_d = '{pull_up: filt_level,
                                pull_down: !filt_level};
    endcase
    bctl_d = pin_selects_modulation && (mode == WII_STOP);
    // The raw pin drives the choice; the host gives a clean level.
    bpwm_d = bctl_d ? wake_pin : bpwm_q;
    // Interrupts never feed these requests.
    wake_d = (mode == WII_SLEEP) && (|evt);
    rst_d  = (mode == WII_FAILSAFE) && pin_evt;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pend_q      <= STAT_RESET;
      stat_q      <= STAT_RESET;
      irq_req_q   <= 1'b0;
      mode_prev_q <= WII_NORMAL;
    end else begin
      pend_q      <= pend_d;
      stat_q      <= stat_d;
      irq_req_q   <= irq_req_d;
      mode_prev_q <= mode_prev_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      level_q <= 1'b0;
      bias_q  <= BIAS_RESET;
      bctl_q  <= 1'b0;
      bpwm_q  <= 1'b0;
      wake_q  <= 1'b0;
      rst_q   <= 1'b0;
    end else begin
      level_q <= level_d;
      bias_q  <= bias_d;
      bctl_q  <= bctl_d;
      bpwm_q  <= bpwm_d;
      wake_q  <= wake_d;
      rst_q   <= rst_d;
    end
  end

  assign wake_status      = stat_q;
  assign pin_level_status = level_q;
  assign pin_bias         = bias_q;
  assign buck_pin_ctrl    = bctl_q;
  assign buck_pwm_sel     = bpwm_q;
  assign wake_req         = wake_q;
  assign restart_req      = rst_q;

endmodule

// ---- bench/wii_wake_irq_asserts.sv ----
// Purpose: Timing and status checks on the wake and interrupt block.
// Assumes: One clock domain; rstn is active low.
// Notes:   Pulse and gap counts arrive from the bound instance.
`timescale 1ns/100ps
module wii_wake_irq_asserts #(
  parameter int unsigned PULSE_CYC = 8,
  parameter int unsigned GAP_CYC   = 8
) (
  input wire logic                   clk_sys,
  input wire logic                   rstn,
  input wire logic                   wake_pin,
  input wire wii_pkg::wii_mode_t     mode,
  input wire logic                   pin_selects_modulation,
  input wire wii_pkg::wii_bias_t     pin_bias_control,
  input wire wii_pkg::wii_stat_t     stat_clear,
  input wire logic                   int_n,
  input wire wii_pkg::wii_stat_t     wake_status,
  input wire wii_pkg::wii_bias_out_t pin_bias,
  input wire logic                   buck_pwm_sel,
  input wire logic                   wake_req,
  input wire logic                   restart_req
);
  import wii_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  int unsigned lo_q;
  int unsigned hi_q;
  // The gap count starts full so the first pulse is not flagged.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lo_q <= 0;
      hi_q <= GAP_CYC;
    end else begin
      lo_q <= int_n ? 0 : lo_q + 1;
      hi_q <= !int_n ? 0 : (hi_q < GAP_CYC ? hi_q + 1 : hi_q);
    end
  end
  property p_len; $rose(int_n) |-> lo_q == PULSE_CYC; endproperty
  a_len: assert property (p_len) else $error("pulse width");
  property p_gap; $fell(int_n) |-> hi_q >= GAP_CYC; endproperty
  a_gap: assert property (p_gap) else $error("pulse gap");
  property p_irqm;
    $fell(int_n) |-> $past(mode) inside {WII_NORMAL, WII_STOP};
  endproperty
  a_irqm: assert property (p_irqm) else $error("pulse mode");
  property p_set;
    |(wake_status & ~$past(wake_status)) |->
      $fell(int_n) || $past(mode) inside {WII_FAILSAFE, WII_SLEEP};
  endproperty
  a_set: assert property (p_set) else $error("status moment");
  property p_hold;
    ($past(wake_status) & ~wake_status & ~$past(stat_clear)) == '0;
  endproperty
  a_hold: assert property (p_hold) else $error("flag lost");
  property p_wake; wake_req |-> $past(mode) == WII_SLEEP; endproperty
  a_wake: assert property (p_wake) else $error("wake mode");
  property p_rst; restart_req |-> $past(mode) == WII_FAILSAFE; endproperty
  a_rst: assert property (p_rst) else $error("restart mode");
  property p_mod;
    $past(pin_selects_modulation && mode == WII_STOP) |->
      buck_pwm_sel == $past(wake_pin);
  endproperty
  a_mod: assert property (p_mod) else $error("modulation");
  property p_bias;
    $past(pin_bias_control) != WII_BIAS_AUTO |->
      pin_bias == {$past(pin_bias_control) == WII_BIAS_UP,
                   $past(pin_bias_control) == WII_BIAS_DOWN};
  endproperty
  a_bias: assert property (p_bias) else $error("bias");
endmodule

// ---- bench/wii_host.sv ----
// Purpose: Host model that acknowledges interrupts by clearing flags.
// Assumes: Flags seen during the pulse are cleared once it ends.
// Notes:   Clears only while ack_en is high, so a test can keep flags.
`timescale 1ns/100ps
module wii_host (
  // Clock and pins
  input  wire logic               clk_sys,
  input  wire logic               int_n,
  input  wire wii_pkg::wii_stat_t wake_status,
  // Control and observation
  input  wire logic               ack_en,
  output wii_pkg::wii_stat_t      stat_clear,
  output int                      irq_cnt
);
  import wii_pkg::*;
  logic      int_q = 1'b1;
  int        cnt_q = 0;
  wii_stat_t clr_q = '0;
  // Sampling on the falling edge keeps clear away from the design's edge.
  // Each register gets one assignment per edge, so a clear lasts one cycle.
  always @(negedge clk_sys) begin
    if (int_q && !int_n) cnt_q <= cnt_q + 1;
    clr_q <= (!int_q && int_n && ack_en) ? wake_status : '0;
    int_q <= int_n;
  end
  assign stat_clear = clr_q;
  assign irq_cnt    = cnt_q;
endmodule

// ---- bench/tb.sv ----
// Purpose: Self-checking bench for the wake input and interrupt block.
// Assumes: Short filter, pulse and gap counts keep the run brief.
// Notes:   Inputs change on the falling clock edge only.
`timescale 1ns/100ps
module tb;
  import wii_pkg::*;
  localparam int unsigned FILTER_CYC = 4;
  localparam int unsigned PULSE_CYC  = 8;
  localparam int unsigned GAP_CYC    = 8;
  logic          clk_sys = 1'b0, rstn = 1'b0, pin = 1'b0, wen = 1'b0;
  logic          cs = 1'b0, cw = 1'b0, psm = 1'b0, pfm = 1'b0, ack = 1'b1;
  wii_mode_t     md = WII_NORMAL;
  wii_bias_t     bias = WII_BIAS_NONE;
  wii_stat_t     sen = '0, sev = '0, clr, ws;
  wii_bias_out_t pb;
  logic          int_n, pls, bpc, bps, wr, rr;
  int            error_cnt = 0, checks_done = 0, irq_cnt, wrc = 0, rrc = 0;
  int            n, a;
  always #20 clk_sys = ~clk_sys;
  always @(negedge clk_sys) begin
    wrc += wr;
    rrc += rr;
  end
  wii_wake_irq #(.FILTER_CYC(FILTER_CYC), .PULSE_CYC(PULSE_CYC),
    .GAP_CYC(GAP_CYC)) wii_wake_irq_i (
    .clk_sys(clk_sys), .rstn(rstn), .wake_pin(pin), .mode(md),
    .wake_enable_bit(wen), .cyclic_sense(cs), .cyclic_window(cw),
    .pin_selects_modulation(psm), .pin_bias_control(bias),
    .src_enable(sen), .src_event(sev), .buck_pfm_to_pwm(pfm),
    .stat_clear(clr), .int_n(int_n), .wake_status(ws),
    .pin_level_status(pls), .pin_bias(pb), .buck_pin_ctrl(bpc),
    .buck_pwm_sel(bps), .wake_req(wr), .restart_req(rr));
  wii_host wii_host_i (.clk_sys(clk_sys), .int_n(int_n), .wake_status(ws),
    .ack_en(ack), .stat_clear(clr), .irq_cnt(irq_cnt));
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_sys);
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic t_pin();
    n = irq_cnt;
    a = wrc + rrc;
    wen = 1'b1;
    pin = 1'b1;
    cyc(12);
    chk(int_n, 1'b0);
    chk(ws.first[0], 1'b1);
    chk(pls, 1'b1);
    cyc(20);
    chk(ws, '0);
    pin = 1'b0;
    cyc(30);
    chk(irq_cnt, n + 2);
    chk(wrc + rrc, a);
    $display("t_pin done");
  endtask
  task automatic t_glitch();
    n = irq_cnt;
    pin = 1'b1;
    cyc(FILTER_CYC - 1);
    pin = 1'b0;
    cyc(30);
    chk(irq_cnt, n);
    chk(ws, '0);
    $display("t_glitch done");
  endtask
  task automatic t_gate();
    n = irq_cnt;
    wen = 1'b0;
    pin = 1'b1;
    cyc(30);
    chk(irq_cnt, n);
    chk(pls, 1'b1);
    wen = 1'b1;
    cs = 1'b1;
    pin = 1'b0;
    cyc(30);
    chk(irq_cnt, n);
    cw = 1'b1;
    pin = 1'b1;
    cyc(30);
    chk(irq_cnt, n + 1);
    cs = 1'b0;
    cw = 1'b0;
    $display("t_gate done");
  endtask
  task automatic t_queue();
    n = irq_cnt;
    sen.first[1] = 1'b1;
    sev.second[0] = 1'b1;
    cyc(1);
    sev = '0;
    cyc(30);
    chk(irq_cnt, n);
    repeat (2) begin
      sev.first[1] = 1'b1;
      cyc(1);
      sev = '0;
      cyc(5);
    end
    cyc(30);
    chk(irq_cnt, n + 2);
    $display("t_queue done");
  endtask
  task automatic t_sleep();
    n = irq_cnt;
    a = wrc;
    md = WII_SLEEP;
    pin = 1'b0;
    cyc(20);
    chk(wrc, a + 1);
    chk(irq_cnt, n);
    chk(ws.first[0], 1'b1);
    a = rrc;
    md = WII_FAILSAFE;
    pin = 1'b1;
    cyc(20);
    chk(rrc, a + 1);
    $display("t_sleep done");
  endtask
  task automatic t_stop();
    ack = 1'b0;
    md = WII_NORMAL;
    cyc(30);
    n = irq_cnt;
    md = WII_STOP;
    cyc(30);
    chk(irq_cnt, n + 1);
    ack = 1'b1;
    pfm = 1'b1;
    cyc(1);
    pfm = 1'b0;
    cyc(30);
    chk(irq_cnt, n + 2);
    chk(ws, '0);
    wen = 1'b0;
    psm = 1'b1;
    // High first, so that each check of buck_pwm_sel sees a change from the value before it.
    for (int v = 1; v >= 0; v--) begin
      pin = v[0];
      cyc(1);
      chk(bps, v[0]);
      chk(bpc, 1'b1);
    end
    psm = 1'b0;
    md = WII_NORMAL;
    $display("t_stop done");
  endtask
  task automatic t_bias();
    for (int i = 0; i < 3; i++) begin
      bias = wii_bias_t'(i);
      cyc(2);
      chk(pb, {i == 2, i == 1});
    end
    cyc(10);
    bias = WII_BIAS_AUTO;
    cyc(2);
    chk(pb, 2'h1);
    pin = 1'b1;
    cyc(10);
    chk(pb, 2'h2);
    $display("t_bias done");
  endtask
  initial begin
    cyc(6);
    rstn = 1'b1;
    cyc(10);
    t_pin();
    t_glitch();
    t_gate();
    t_queue();
    t_sleep();
    t_stop();
    t_bias();
    wrap_up();
  end
  // The tests need well under a thousand cycles; this cuts a hang short.
  initial begin
    repeat (4000) @(posedge clk_sys);
    error_cnt++;
    wrap_up();
  end
endmodule
bind wii_wake_irq wii_wake_irq_asserts #(.PULSE_CYC(PULSE_CYC),
  .GAP_CYC(GAP_CYC)) wii_wake_irq_asserts_i (
  .clk_sys(clk_sys), .rstn(rstn), .wake_pin(wake_pin), .mode(mode),
  .pin_selects_modulation(pin_selects_modulation),
  .pin_bias_control(pin_bias_control), .stat_clear(stat_clear),
  .int_n(int_n), .wake_status(wake_status), .pin_bias(pin_bias),
  .buck_pwm_sel(buck_pwm_sel), .wake_req(wake_req),
  .restart_req(restart_req));
